// [rtl/camio_defines.svh]
`ifndef CAMIO_DEFINES_SVH
`define CAMIO_DEFINES_SVH

// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define CAMIO_OFF_LINE_PICK   8'h00
`define CAMIO_OFF_LINE_INV    8'h04
`define CAMIO_OFF_LINE_DIR    8'h08
`define CAMIO_OFF_LINE_SRC    8'h0C
`define CAMIO_OFF_USER_PICK   8'h10
`define CAMIO_OFF_USER_VAL    8'h14
`define CAMIO_OFF_LEVEL_READ  8'h18
`define CAMIO_OFF_ALL_LEVEL   8'h1C
`define CAMIO_OFF_BURST_TOTAL 8'h20
`define CAMIO_OFF_TRIG_CFG    8'h24
`define CAMIO_OFF_ARM_STAT    8'h28

// ---------------------------------------------
// Line indices and field positions
// ---------------------------------------------
`define CAMIO_LINE_OPTO_IN    2'h0
`define CAMIO_LINE_OPTO_OUT   2'h1
`define CAMIO_LINE_BIDIR      2'h2
`define CAMIO_BIT_TRIG_TYPE   0
`define CAMIO_BIT_ROLLING     1

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define CAMIO_RST_ALL_STD     4'h6
`define CAMIO_RST_ALL_HT      4'h2
`define CAMIO_RST_BURST_TOTAL 8'h01
`define CAMIO_RST_USER_VAL    3'h0
`define CAMIO_RST_INV         3'h0

`endif

// [rtl/camio_pkg.sv]
package camio_pkg;

  // Output source codes, in selector order
  typedef enum logic [2:0] {
    src_strobe,
    src_user_a,
    src_user_b,
    src_user_c,
    src_exposing,
    src_single_arm,
    src_burst_arm
  } camio_src_t;

  // State of one output line
  typedef struct packed {
    logic drive;
  } camio_line_t;

  // State of the line controller
  typedef struct packed {
    logic [1:0]  pick;
    logic [2:0]  inv;
    logic        dir;
    camio_src_t  src_out;
    camio_src_t  src_bid;
    logic [1:0]  upick;
    logic [2:0]  uval;
    logic [7:0]  burst_total;
    logic        trig_type;
    logic        rolling;
    logic        ack;
    logic [31:0] rdat;
    logic [2:0]  sin;
    logic [2:0]  sbd;
    logic        lvl_in;
    logic        lvl_bd;
    logic [3:0]  all_lvl;
    logic        strobe_n;
    logic        exposing_n;
    logic        sbusy;
    logic        bbusy;
    logic [7:0]  bcnt;
  } camio_state_t;

endpackage

// [rtl/camio_src_if.sv]
`timescale 1ns/100ps

// Candidate output sources shared by the line drivers
interface camio_src_if;
  logic       strobe_n;
  logic [2:0] user_lvl;
  logic       exposing_n;
  logic       single_arm;
  logic       burst_arm;

  modport src  (output strobe_n, user_lvl, exposing_n, single_arm, burst_arm);
  modport sink (input  strobe_n, user_lvl, exposing_n, single_arm, burst_arm);
endinterface

// [rtl/camio_out_line.sv]
`timescale 1ns/100ps

module camio_out_line (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Sources
  camio_src_if.sink              src,
  // Line settings
  input  camio_pkg::camio_src_t  pick,
  input  wire logic              invert,
  // Line level
  output logic                   drive
);

  camio_pkg::camio_line_t s_q;
  camio_pkg::camio_line_t s_d;

  // ---------------------------------------------
  // Source selection and inversion
  // ---------------------------------------------
  always_comb begin
    logic sel;
    sel = 1'b0;
    unique case (pick)
      camio_pkg::src_strobe:     sel = src.strobe_n;
      camio_pkg::src_user_a:     sel = src.user_lvl[0];
      camio_pkg::src_user_b:     sel = src.user_lvl[1];
      camio_pkg::src_user_c:     sel = src.user_lvl[2];
      camio_pkg::src_exposing:   sel = src.exposing_n;
      camio_pkg::src_single_arm: sel = src.single_arm;
      camio_pkg::src_burst_arm:  sel = src.burst_arm;
      default:                   sel = 1'b0;
    endcase
    s_d       = s_q;
    s_d.drive = sel ^ invert;
  end

  // Registered line level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign drive = s_q.drive;

endmodule

// [rtl/camio_ctrl.sv]
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "camio_defines.svh"

// Summary of operation
// - Input invert flag resets false; when true the sampled input is inverted.
// - Opto output is output only; bidirectional line outputs only in output direction.
// - Opto output drives from reset; bidirectional drives only after direction changes.
// - Each output line has its own seven-way source selector.
// - Every output source selector resets to the first user level.
// - Strobe goes low on trigger, high after exposure delay plus exposure.
// - User-level source drives the stored user level value constantly.
// - Global shutter: exposing indicator low from exposure start to exposure end.
// - Rolling shutter: exposing indicator goes low when last line exposure ends.
// - Generic arm indicator low while ready, high from trigger until ready again.
// - Single-frame arm source low from trigger until frame transfer completes.
// - Burst arm source low from trigger until all burst frames transfer.
// - User level pick selects one of three values; values reset false.
// - Output invert flag resets false; when true the source is inverted.
// - Standard variant per-line status resets false, true, true.
// - Higher-threshold variant per-line status resets false, true, false.
// - All-lines word: opto in bit0, opto out bit1, bidir bit2, post-inversion.
// - All-lines word resets 0x6 on standard and 0x2 on higher-threshold.
// - Bidirectional line resets as input; direction setting switches it.

module camio_ctrl #(
  parameter bit HI_THRESH = 1'b0
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Acquisition events
  input  wire logic        frame_trig,
  input  wire logic        burst_trig,
  input  wire logic        exp_start,
  input  wire logic        exp_end,
  input  wire logic        last_line_end,
  input  wire logic        frame_done,
  // Lines
  input  wire logic        opto_in_i,
  output logic             opto_out_o,
  input  wire logic        bidir_i,
  output logic             bidir_o,
  output logic             bidir_oe
);

  // ---------------------------------------------
  // Constants and state
  // ---------------------------------------------

  // Bidirectional input idles high on standard parts, low otherwise
  localparam logic BD_RST = ~HI_THRESH;

  localparam logic [3:0] ALL_RST =
    HI_THRESH ? `CAMIO_RST_ALL_HT : `CAMIO_RST_ALL_STD;

  localparam camio_pkg::camio_state_t RST = '{
    pick:        `CAMIO_LINE_OPTO_IN,
    inv:         `CAMIO_RST_INV,
    dir:         1'b0,
    src_out:     camio_pkg::src_user_a,
    src_bid:     camio_pkg::src_user_a,
    upick:       2'h0,
    uval:        `CAMIO_RST_USER_VAL,
    burst_total: `CAMIO_RST_BURST_TOTAL,
    trig_type:   1'b0,
    rolling:     1'b0,
    ack:         1'b0,
    rdat:        32'h0000_0000,
    sin:         3'h0,
    sbd:         {3{BD_RST}},
    lvl_in:      1'b0,
    lvl_bd:      BD_RST,
    all_lvl:     ALL_RST,
    strobe_n:    1'b1,
    exposing_n:  1'b1,
    sbusy:       1'b0,
    bbusy:       1'b0,
    bcnt:        8'h00
  };

  camio_pkg::camio_state_t s_q;
  camio_pkg::camio_state_t s_d;

  camio_src_if src_if ();

  logic out_drv;
  logic bid_drv;

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------

  // Word address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // Line or user index within the three legal values
  function automatic logic idx_ok(input logic [1:0] v);
    return v != 2'h3;
  endfunction

  // ---------------------------------------------
  // Next-state logic
  // ---------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic        req;
    logic        wr;
    logic        bid_stat;
    logic        arm;
    rd       = 32'h0000_0000;
    bid_stat = 1'b0;
    s_d      = s_q;
    req = cyc_i & stb_i;
    wr  = req & we_i & s_q.ack & sel_i[0];
    arm = s_q.trig_type ? s_q.bbusy : s_q.sbusy;

    // Three-stage pin synchronisers
    s_d.sin = {s_q.sin[1:0], opto_in_i};
    s_d.sbd = {s_q.sbd[1:0], bidir_i};
    if (s_q.sin[1] == s_q.sin[2]) begin
      s_d.lvl_in = s_q.sin[2];
    end
    if (s_q.sbd[1] == s_q.sbd[2]) begin
      s_d.lvl_bd = s_q.sbd[2];
    end

    // Line status, post-inversion
    bid_stat = s_q.dir ? ~bid_drv
                       : (s_q.lvl_bd ^ s_q.inv[2]);
    s_d.all_lvl = {1'b0, bid_stat, ~out_drv,
                   s_q.lvl_in ^ s_q.inv[0]};

    // Strobe: low from trigger to exposure end
    if (frame_trig) begin
      s_d.strobe_n = 1'b0;
    end else if (exp_end) begin
      s_d.strobe_n = 1'b1;
    end

    // Exposing indicator per shutter type
    if (!s_q.rolling) begin
      if (exp_start) begin
        s_d.exposing_n = 1'b0;
      end else if (exp_end) begin
        s_d.exposing_n = 1'b1;
      end
    end else begin
      if (last_line_end) begin
        s_d.exposing_n = 1'b0;
      end else if (frame_done) begin
        s_d.exposing_n = 1'b1;
      end
    end

    // Single-frame busy, trigger wins over completion
    if (frame_trig && !s_q.trig_type) begin
      s_d.sbusy = 1'b1;
    end else if (frame_done) begin
      s_d.sbusy = 1'b0;
    end

    // Burst busy and frame count
    if (s_q.bbusy && frame_done) begin
      if ({1'b0, s_q.bcnt} + 9'h001 >= {1'b0, s_q.burst_total}) begin
        s_d.bbusy = 1'b0;
      end else begin
        s_d.bcnt = s_q.bcnt + 8'h01;
      end
    end
    if (burst_trig && s_q.trig_type && !s_d.bbusy) begin
      s_d.bbusy = 1'b1;
      s_d.bcnt  = 8'h00;
    end

    // Read mux, no side effects
    if (hit(adr_i, `CAMIO_OFF_LINE_PICK)) begin
      rd[1:0] = s_q.pick;
    end else if (hit(adr_i, `CAMIO_OFF_LINE_INV)) begin
      rd[0] = s_q.inv[s_q.pick];
    end else if (hit(adr_i, `CAMIO_OFF_LINE_DIR)) begin
      if (s_q.pick == `CAMIO_LINE_BIDIR) begin
        rd[0] = s_q.dir;
      end else begin
        rd[0] = (s_q.pick == `CAMIO_LINE_OPTO_OUT);
      end
    end else if (hit(adr_i, `CAMIO_OFF_LINE_SRC)) begin
      if (s_q.pick == `CAMIO_LINE_OPTO_OUT) begin
        rd[2:0] = s_q.src_out;
      end else if (s_q.pick == `CAMIO_LINE_BIDIR) begin
        rd[2:0] = s_q.src_bid;
      end
    end else if (hit(adr_i, `CAMIO_OFF_USER_PICK)) begin
      rd[1:0] = s_q.upick;
    end else if (hit(adr_i, `CAMIO_OFF_USER_VAL)) begin
      rd[0] = s_q.uval[s_q.upick];
    end else if (hit(adr_i, `CAMIO_OFF_LEVEL_READ)) begin
      rd[0] = s_q.all_lvl[s_q.pick];
    end else if (hit(adr_i, `CAMIO_OFF_ALL_LEVEL)) begin
      rd[3:0] = s_q.all_lvl;
    end else if (hit(adr_i, `CAMIO_OFF_BURST_TOTAL)) begin
      rd[7:0] = s_q.burst_total;
    end else if (hit(adr_i, `CAMIO_OFF_TRIG_CFG)) begin
      rd[`CAMIO_BIT_TRIG_TYPE] = s_q.trig_type;
      rd[`CAMIO_BIT_ROLLING]   = s_q.rolling;
    end else if (hit(adr_i, `CAMIO_OFF_ARM_STAT)) begin
      rd[0] = arm;
    end

    // Bus handshake: ack one cycle after request
    s_d.ack = req & ~s_q.ack;
    if (req && !s_q.ack) begin
      s_d.rdat = rd;
    end

    // Register writes, taken at the ack edge
    if (wr) begin
      if (hit(adr_i, `CAMIO_OFF_LINE_PICK) && idx_ok(dat_i[1:0])) begin
        s_d.pick = dat_i[1:0];
      end
      if (hit(adr_i, `CAMIO_OFF_LINE_INV)) begin
        s_d.inv[s_q.pick] = dat_i[0];
      end
      if (hit(adr_i, `CAMIO_OFF_LINE_DIR)
          && s_q.pick == `CAMIO_LINE_BIDIR) begin
        s_d.dir = dat_i[0];
      end
      if (hit(adr_i, `CAMIO_OFF_LINE_SRC) && dat_i[2:0] != 3'h7) begin
        if (s_q.pick == `CAMIO_LINE_OPTO_OUT) begin
          s_d.src_out = camio_pkg::camio_src_t'(dat_i[2:0]);
        end else if (s_q.pick == `CAMIO_LINE_BIDIR) begin
          s_d.src_bid = camio_pkg::camio_src_t'(dat_i[2:0]);
        end
      end
      if (hit(adr_i, `CAMIO_OFF_USER_PICK) && idx_ok(dat_i[1:0])) begin
        s_d.upick = dat_i[1:0];
      end
      if (hit(adr_i, `CAMIO_OFF_USER_VAL)) begin
        s_d.uval[s_q.upick] = dat_i[0];
      end
      if (hit(adr_i, `CAMIO_OFF_BURST_TOTAL) && dat_i[7:0] != 8'h00) begin
        s_d.burst_total = dat_i[7:0];
      end
      if (hit(adr_i, `CAMIO_OFF_TRIG_CFG)) begin
        s_d.trig_type = dat_i[`CAMIO_BIT_TRIG_TYPE];
        s_d.rolling   = dat_i[`CAMIO_BIT_ROLLING];
      end
    end
  end

  // ---------------------------------------------
  // State register
  // ---------------------------------------------

  // Power-on values for all control and status
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------
  // Source bus to the line drivers
  // ---------------------------------------------

  // Arm sources are low while busy
  assign src_if.strobe_n   = s_q.strobe_n;
  assign src_if.user_lvl   = s_q.uval;
  assign src_if.exposing_n = s_q.exposing_n;
  assign src_if.single_arm = ~s_q.sbusy;
  assign src_if.burst_arm  = ~s_q.bbusy;

  // ---------------------------------------------
  // Output line drivers
  // ---------------------------------------------

  // Opto-isolated output line
  camio_out_line u_opto_out (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .src     (src_if.sink),
    .pick    (s_q.src_out),
    .invert  (s_q.inv[1]),
    .drive   (out_drv)
  );

  // Bidirectional line, output path
  camio_out_line u_bidir_out (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .src     (src_if.sink),
    .pick    (s_q.src_bid),
    .invert  (s_q.inv[2]),
    .drive   (bid_drv)
  );

  // ---------------------------------------------
  // Pins and bus outputs
  // ---------------------------------------------

  // Opto output always driven; bidir enable follows direction
  assign opto_out_o = out_drv;
  assign bidir_o    = bid_drv;
  assign bidir_oe   = s_q.dir;
  assign dat_o      = s_q.rdat;
  assign ack_o      = s_q.ack;

endmodule

// [bench/camio_assertions.sv]
`timescale 1ns/100ps

// ----------------------
// Port checker
// ----------------------
module camio_assertions (
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  // Events
  input wire logic frame_trig,
  input wire logic burst_trig,
  input wire logic exp_start,
  input wire logic exp_end,
  input wire logic last_line_end,
  input wire logic frame_done,
  // Lines
  input wire logic opto_out_o,
  input wire logic bidir_o,
  input wire logic bidir_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Accepted write, and anything allowed to move a line
  wire wr_done = cyc_i & stb_i & we_i & ack_o;
  wire cause   = wr_done | frame_trig | burst_trig | exp_start | exp_end | last_line_end
                 | frame_done;

  // Bus answer
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");

  // Levels right after reset
  a_reset_opto: assert property (!$past(resetn) |-> !opto_out_o) else $error("opto up");
  a_reset_bidir: assert property (!$past(resetn) |-> !bidir_oe && !bidir_o) else $error("bd");

  // Line levels move only two edges after a cause, direction one edge after a write; reads move nothing
  a_dir_by_write: assert property ($changed(bidir_oe) |-> $past(wr_done)) else $error("oe");
  a_opto_cause: assert property ($changed(opto_out_o) |-> $past(cause, 2)) else $error("opto");
  a_bidir_cause: assert property ($changed(bidir_o) |-> $past(cause, 2)) else $error("bidir");

  // Main scenarios
  c_write: cover property (wr_done);
  c_oe_on: cover property ($rose(bidir_oe));
  c_strobe: cover property (frame_trig ##2 $fell(opto_out_o));
endmodule

bind camio_ctrl camio_assertions u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .ack_o(ack_o), .frame_trig(frame_trig), .burst_trig(burst_trig),
  .exp_start(exp_start), .exp_end(exp_end), .last_line_end(last_line_end),
  .frame_done(frame_done), .opto_out_o(opto_out_o), .bidir_o(bidir_o),
  .bidir_oe(bidir_oe)
);

// [bench/camio_line_model.sv]
`timescale 1ns/100ps

// ----------------------
// Outside circuitry
// ----------------------
module camio_line_model #(
  parameter logic PULL = 1'b1
) (
  // Bench controls
  input wire logic sensor_lvl,
  input wire logic ext_en,
  input wire logic ext_lvl,
  // Camera side
  input wire logic bidir_o,
  input wire logic bidir_oe,
  output logic     opto_in_i,
  output logic     bidir_i
);
  // Hardware-trigger sensor on the opto input
  assign opto_in_i = sensor_lvl;
  // Shared wire: camera, outside driver or pull resistor; both driving is a clash
  assign bidir_i = bidir_oe ? (ext_en ? 1'bx : bidir_o) : (ext_en ? ext_lvl : PULL);
endmodule

// [bench/camio_ctrl_test.sv]
`timescale 1ns/100ps

// ----------------------
// Testbench
// ----------------------
module camio_ctrl_test;
  logic        ref_clk, resetn, cyc, stb, we, ack_o;
  logic [7:0]  adr;
  logic [31:0] wdat, dat_o, rdat;
  logic [3:0]  sel;
  logic [5:0]  ev;
  logic        opto_in, opto_out, bid_i, bid_o, bid_oe, sens, ext_en, ext_lvl;
  logic [31:0] dat_o_ht, rdat_ht;
  logic        bid_i_ht, bid_o_ht, bid_oe_ht;
  int          fails, n_checks, i;

  camio_ctrl #(.HI_THRESH(1'b0)) uut (
    .ref_clk(ref_clk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o),
    .frame_trig(ev[0]), .burst_trig(ev[1]), .exp_start(ev[2]), .exp_end(ev[3]),
    .last_line_end(ev[4]), .frame_done(ev[5]), .opto_in_i(opto_in),
    .opto_out_o(opto_out), .bidir_i(bid_i), .bidir_o(bid_o), .bidir_oe(bid_oe));

  camio_line_model u_line (.sensor_lvl(sens), .ext_en(ext_en), .ext_lvl(ext_lvl),
    .bidir_o(bid_o), .bidir_oe(bid_oe), .opto_in_i(opto_in), .bidir_i(bid_i));

  // Higher-threshold variant on the same bus, bidir line pulled low
  camio_ctrl #(.HI_THRESH(1'b1)) uut_ht (
    .ref_clk(ref_clk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(dat_o_ht), .ack_o(),
    .frame_trig(ev[0]), .burst_trig(ev[1]), .exp_start(ev[2]), .exp_end(ev[3]),
    .last_line_end(ev[4]), .frame_done(ev[5]), .opto_in_i(opto_in),
    .opto_out_o(), .bidir_i(bid_i_ht), .bidir_o(bid_o_ht), .bidir_oe(bid_oe_ht));

  camio_line_model #(.PULL(1'b0)) u_line_ht (.sensor_lvl(sens), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .bidir_o(bid_o_ht), .bidir_oe(bid_oe_ht), .opto_in_i(),
    .bidir_i(bid_i_ht));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------
  // Tasks
  // ----------------------
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_checks++;
    if (got !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  // One classic bus cycle, held until ack
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      input logic [3:0] s);
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    sel  <= s;
    do @(posedge ref_clk); while (ack_o !== 1'b1);
    rdat = dat_o;
    rdat_ht = dat_o_ht;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h0, 4'hF);
    chk(rdat, {24'h0, e});
  endtask

  // Let a change reach the opto output, then compare it
  task automatic ln(input logic e);
    repeat (4) @(posedge ref_clk);
    chk({31'h0, opto_out}, {31'h0, e});
  endtask

  // One-cycle acquisition event
  task automatic pulse(input int k);
    @(posedge ref_clk);
    ev[k] <= 1'b1;
    @(posedge ref_clk);
    ev <= 6'h00;
  endtask

  // Verdict
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #400000;
    fails++;
    end_of_test;
  end

  // ----------------------
  // Tests
  // ----------------------
  initial begin
    {resetn, cyc, stb, we, adr, wdat, sel, ev, sens, ext_en, ext_lvl} = '0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    // Power-on values
    rd(8'h1C, 8'h6);
    chk(rdat_ht, 32'h2);
    for (i = 0; i < 3; i++) begin
      wr(8'h00, i[7:0]);
      rd(8'h18, {7'h0, i != 0});
      chk(rdat_ht, {31'h0, i == 1});
      rd(8'h08, {7'h0, i == 1});
      rd(8'h0C, {7'h0, i != 0});
    end
    rd(8'h04, 8'h0);
    rd(8'h14, 8'h0);
    chk({30'h0, opto_out, bid_oe}, 32'h0);
    // Input inversion and all-lines word
    wr(8'h00, 8'h0);
    wr(8'h04, 8'h1);
    rd(8'h1C, 8'h7);
    sens <= 1'b1;
    ext_en <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(8'h1C, 8'h2);
    wr(8'h04, 8'h0);
    repeat (6) @(posedge ref_clk);
    rd(8'h1C, 8'h3);
    sens <= 1'b0;
    ext_en <= 1'b0;
    // Each user level through the opto output
    wr(8'h00, 8'h1);
    for (i = 0; i < 3; i++) begin
      wr(8'h10, i[7:0]);
      wr(8'h14, 8'h1);
      wr(8'h0C, 8'(i + 1));
      ln(1'b1);
      rd(8'h1C, 8'h4);
      wr(8'h14, 8'h0);
      ln(1'b0);
    end
    wr(8'h0C, 8'h7);
    rd(8'h0C, 8'h3);
    wr(8'h04, 8'h1);
    ln(1'b1);
    wr(8'h04, 8'h0);
    ln(1'b0);
    // Strobe
    wr(8'h0C, 8'h0);
    ln(1'b1);
    pulse(0);
    ln(1'b0);
    pulse(2);
    ln(1'b0);
    pulse(3);
    ln(1'b1);
    // Exposing, global then rolling
    wr(8'h0C, 8'h4);
    pulse(2);
    ln(1'b0);
    pulse(3);
    ln(1'b1);
    wr(8'h24, 8'h2);
    pulse(4);
    ln(1'b0);
    pulse(5);
    ln(1'b1);
    // Single-frame arm
    wr(8'h24, 8'h0);
    wr(8'h0C, 8'h5);
    pulse(0);
    ln(1'b0);
    rd(8'h28, 8'h1);
    pulse(5);
    ln(1'b1);
    rd(8'h28, 8'h0);
    // Burst arm over two frames
    wr(8'h24, 8'h1);
    wr(8'h20, 8'h2);
    wr(8'h0C, 8'h6);
    pulse(1);
    ln(1'b0);
    pulse(5);
    ln(1'b0);
    pulse(5);
    ln(1'b1);
    // Bidirectional line as output
    wr(8'h00, 8'h2);
    wr(8'h08, 8'h1);
    ln(1'b1);
    chk({30'h0, bid_oe, bid_o}, 32'h2);
    wr(8'h04, 8'h1);
    ln(1'b1);
    chk({30'h0, bid_oe, bid_o}, 32'h3);
    wr(8'h08, 8'h0);
    ln(1'b1);
    chk({31'h0, bid_oe}, 32'h0);
    wr(8'h00, 8'h1);
    wr(8'h08, 8'h0);
    rd(8'h08, 8'h1);
    // Refused bus accesses
    wr(8'h3C, 8'h5);
    rd(8'h3C, 8'h0);
    xfer(8'h14, 1'b1, 8'h1, 4'h0);
    rd(8'h14, 8'h0);
    // Second reset
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(8'h1C, 8'h6);
    chk(rdat_ht, 32'h2);
    rd(8'h0C, 8'h0);
    wr(8'h00, 8'h1);
    rd(8'h0C, 8'h1);
    end_of_test;
  end
endmodule
